// ---- pxm_pkg.sv ----
// constants and carrier types for the pixel multiplexer and palette lookup
package pxm_pkg;

  // ---------------------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------------------
  localparam int LANES     = 5;
  localparam int ADDR_W    = 8;
  localparam int COMP_W    = 8;
  localparam int ENTRY_W   = 3 * COMP_W;
  localparam int PAL_DEPTH = 256;
  localparam int OVL_DEPTH = 4;

  // ---------------------------------------------------------------------------
  // serializer lane limits (lane a is index 0)
  // ---------------------------------------------------------------------------
  localparam logic [2:0] LANE_FIRST  = 3'h0;
  localparam logic [2:0] LAST_LANE_4 = 3'h3;
  localparam logic [2:0] LAST_LANE_5 = 3'h4;

  // ---------------------------------------------------------------------------
  // microprocessor port: select codes, control fields, component sequencing
  // ---------------------------------------------------------------------------
  localparam logic [1:0] SEL_ADDR    = 2'h0;
  localparam logic [1:0] SEL_COLOR   = 2'h1;
  localparam logic [1:0] SEL_CTRL    = 2'h2;
  localparam logic [1:0] SEL_OVERLAY = 2'h3;

  localparam int         CTRL_OVL_EN_BIT = 6;
  localparam int         CTRL_MUX5_BIT   = 7;
  localparam logic [7:0] CTRL_RESET      = 8'h40;

  localparam logic [1:0] COMP_RED   = 2'h0;
  localparam logic [1:0] COMP_GREEN = 2'h1;
  localparam logic [1:0] COMP_BLUE  = 2'h2;

  localparam logic [1:0]         OSEL_COLOR  = 2'h0;
  localparam logic [ENTRY_W-1:0] BLANK_LEVEL = 24'h000000;

  // ---------------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [COMP_W-1:0] red;
    logic [COMP_W-1:0] green;
    logic [COMP_W-1:0] blue;
  } pxm_rgb_t;

  typedef struct packed {
    logic                         blank_n;
    logic [LANES-1:0]             overlay_select_high_lanes;
    logic [LANES-1:0]             overlay_select_low_lanes;
    logic [LANES-1:0][ADDR_W-1:0] addr;
  } pxm_group_t;

  typedef struct packed {
    logic       ce_n;
    logic [1:0] sel;
    logic       rd_wr_n;
    logic [7:0] data;
  } pxm_mpu_t;

endpackage : pxm_pkg

// ---- pxm_palette_mux.sv ----
// pixel group capture, serializer, palette lookup and microprocessor palette port
`timescale 1ns/1ps

module pxm_palette_mux
  import pxm_pkg::*;
(
  input  wire logic                CORE_CLK,
  input  wire logic                RST,
  input  wire logic                LOAD_CLK,
  input  wire pxm_pkg::pxm_group_t PIXEL_GROUP,
  input  wire pxm_pkg::pxm_mpu_t   MPU_PINS,
  output logic [7:0]               MPU_DATA_OUT,
  output logic                     MPU_DATA_OE,
  output pxm_pkg::pxm_rgb_t        VIDEO_RGB,
  output logic                     VIDEO_VALID
);
  import pxm_pkg::*;

  // ---------------------------------------------------------------------------
  // state types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [2:0]            rst_sync;
    logic                  rst_q;
    logic                  ptr;
    pxm_group_t [1:0]      bank;
  } pxm_load_t;

  typedef struct packed {
    pxm_mpu_t                           mpu_s1;
    pxm_mpu_t                           mpu_s2;
    pxm_mpu_t                           mpu_s3;
    logic                               ce_f;
    logic [1:0]                         sel_q;
    logic                               rd_q;
    logic [7:0]                         ctrl;
    logic [7:0]                         addr_reg;
    logic [1:0]                         comp;
    logic [1:0][COMP_W-1:0]             stage;
    logic [OVL_DEPTH-1:0][ENTRY_W-1:0]  ovl_pal;
    logic [7:0]                         dout;
    logic                               doe;
    logic                               tog_s1;
    logic                               tog_s2;
    logic                               tog_s3;
    logic                               tog_f;
    pxm_group_t                         shift;
    logic [2:0]                         lane;
    logic                               active;
    pxm_rgb_t                           rgb;
    logic                               valid;
  } pxm_core_t;

  pxm_load_t  ld;
  pxm_load_t  next_ld;
  pxm_core_t  s;
  pxm_core_t  next_s;

  logic [ENTRY_W-1:0] color_pal [PAL_DEPTH];
  logic               pal_we;
  logic [ADDR_W-1:0]  pal_wa;
  logic [ENTRY_W-1:0] pal_wd;

  logic               rst_load;
  logic               ce_stable;
  logic               ce_fall;
  logic               ce_rise;
  logic               new_grp;
  logic [2:0]         last_lane;
  logic [1:0]         osel;
  logic               use_ovl;
  logic [ENTRY_W-1:0] entry;

  // a synchronised level only counts once its last two stages agree
  function automatic logic agree(input logic a,
                                 input logic b);
    return (a == b);
  endfunction : agree

  function automatic logic [COMP_W-1:0] comp_byte(input logic [ENTRY_W-1:0] e,
                                                  input logic [1:0]         c);
    logic [COMP_W-1:0] b;
    b = e[COMP_W-1:0];
    unique case (c)
      COMP_RED:   b = e[ENTRY_W-1 -: COMP_W];
      COMP_GREEN: b = e[2*COMP_W-1 -: COMP_W];
      default:    b = e[COMP_W-1:0];
    endcase
    return b;
  endfunction : comp_byte

  // ---------------------------------------------------------------------------
  // load domain: group capture into alternating banks
  // ---------------------------------------------------------------------------
  // two banks so the core side reads a bank that stays put for a whole group
  // reset enters and leaves only when stages two and three agree, so a
  // half-settled first stage cannot end the load-side reset one edge early
  assign rst_load = ld.rst_q;

  always_comb begin
    next_ld             = ld;
    next_ld.rst_sync    = {ld.rst_sync[1:0], RST};
    if (agree(ld.rst_sync[1], ld.rst_sync[2])) begin
      next_ld.rst_q = ld.rst_sync[2];
    end
    if (rst_load) begin
      next_ld.ptr = 1'b0;
    end else begin
      next_ld.bank[ld.ptr] = PIXEL_GROUP;
      next_ld.ptr          = ~ld.ptr;
    end
  end

  always_ff @(posedge LOAD_CLK) begin
    ld <= next_ld;
  end

  // ---------------------------------------------------------------------------
  // core domain: synchronisers and edge detection
  // ---------------------------------------------------------------------------
  assign ce_stable = agree(s.mpu_s2.ce_n, s.mpu_s3.ce_n);
  assign ce_fall   = ce_stable && !s.mpu_s3.ce_n && s.ce_f;
  assign ce_rise   = ce_stable && s.mpu_s3.ce_n && !s.ce_f;
  // no fixed phase to the load strobe is assumed; the pointer toggle is the event
  assign new_grp   = agree(s.tog_s2, s.tog_s3) && (s.tog_s3 != s.tog_f);
  assign last_lane = s.ctrl[CTRL_MUX5_BIT] ? LAST_LANE_5 : LAST_LANE_4;

  // ---------------------------------------------------------------------------
  // lookup of the pixel in the current lane
  // ---------------------------------------------------------------------------
  always_comb begin
    osel    = {s.shift.overlay_select_high_lanes[s.lane],
               s.shift.overlay_select_low_lanes[s.lane]};
    use_ovl = !s.ctrl[CTRL_OVL_EN_BIT] || (osel != OSEL_COLOR);
    if (use_ovl) begin
      entry = s.ovl_pal[osel];
    end else begin
      entry = color_pal[s.shift.addr[s.lane]];
    end
    if (!s.shift.blank_n) begin
      entry = BLANK_LEVEL;
    end
  end

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    next_s        = s;
    pal_we        = 1'b0;
    pal_wa        = s.addr_reg;
    pal_wd        = {s.stage[0], s.stage[1], s.mpu_s3.data};
    next_s.mpu_s1 = MPU_PINS;
    next_s.mpu_s2 = s.mpu_s1;
    next_s.mpu_s3 = s.mpu_s2;
    next_s.tog_s1 = ld.ptr;
    next_s.tog_s2 = s.tog_s1;
    next_s.tog_s3 = s.tog_s2;
    if (ce_stable) begin
      next_s.ce_f = s.mpu_s3.ce_n;
    end
    if (agree(s.tog_s2, s.tog_s3)) begin
      next_s.tog_f = s.tog_s3;
    end

    // microprocessor access starts: latch select and direction, drive read data
    if (ce_fall) begin
      next_s.sel_q = s.mpu_s3.sel;
      next_s.rd_q  = s.mpu_s3.rd_wr_n;
      if (s.mpu_s3.rd_wr_n) begin
        next_s.doe = 1'b1;
        unique case (s.mpu_s3.sel)
          SEL_ADDR:    next_s.dout = s.addr_reg;
          SEL_CTRL:    next_s.dout = s.ctrl;
          SEL_COLOR:   next_s.dout = comp_byte(color_pal[s.addr_reg], s.comp);
          SEL_OVERLAY: next_s.dout = comp_byte(s.ovl_pal[s.addr_reg[1:0]], s.comp);
        endcase
      end
    end

    // access ends: writes take the data bus, palette accesses step red-green-blue
    if (ce_rise) begin
      next_s.doe = 1'b0;
      unique case (s.sel_q)
        SEL_ADDR: begin
          if (!s.rd_q) begin
            next_s.addr_reg = s.mpu_s3.data;
            next_s.comp     = COMP_RED;
          end
        end
        SEL_CTRL: begin
          if (!s.rd_q) begin
            next_s.ctrl = s.mpu_s3.data;
          end
        end
        SEL_COLOR, SEL_OVERLAY: begin
          if (s.comp == COMP_BLUE) begin
            // whole entry lands at once so video never shows a half-written color
            if (!s.rd_q && s.sel_q == SEL_COLOR) begin
              pal_we = 1'b1;
            end
            if (!s.rd_q && s.sel_q == SEL_OVERLAY) begin
              next_s.ovl_pal[s.addr_reg[1:0]] = pal_wd;
            end
            next_s.comp     = COMP_RED;
            next_s.addr_reg = s.addr_reg + 8'h01;
          end else begin
            if (!s.rd_q) begin
              next_s.stage[s.comp[0]] = s.mpu_s3.data;
            end
            next_s.comp = s.comp + 2'h1;
          end
        end
      endcase
    end

    // serializer and output stage
    if (s.active) begin
      next_s.rgb   = pxm_rgb_t'(entry);
      next_s.valid = 1'b1;
      next_s.lane  = s.lane + 3'h1;
      if (s.lane == last_lane) begin
        next_s.active = 1'b0;
      end
    end else begin
      next_s.rgb   = pxm_rgb_t'(BLANK_LEVEL);
      next_s.valid = 1'b0;
    end
    // the newest bank is the one before the synced pointer
    if (new_grp) begin
      next_s.shift  = ld.bank[~s.tog_s3];
      next_s.lane   = LANE_FIRST;
      next_s.active = 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      s             <= '0;
      s.ctrl        <= CTRL_RESET;
      s.ce_f        <= 1'b1;
      s.mpu_s1.ce_n <= 1'b1;
      s.mpu_s2.ce_n <= 1'b1;
      s.mpu_s3.ce_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // palette has no reset; software loads it before display
  always_ff @(posedge CORE_CLK) begin
    if (pal_we) begin
      color_pal[pal_wa] <= pal_wd;
    end
  end

  assign MPU_DATA_OUT = s.dout;
  assign MPU_DATA_OE  = s.doe;
  assign VIDEO_RGB    = s.rgb;
  assign VIDEO_VALID  = s.valid;

endmodule : pxm_palette_mux

// ---- pxm_palette_mux_monitor.sv ----
// port checker for the pixel multiplexer and palette lookup
`timescale 1ns/1ps
module pxm_palette_mux_monitor
  import pxm_pkg::*;
(
  input wire logic                CORE_CLK,
  input wire logic                RST,
  input wire logic                LOAD_CLK,
  input wire pxm_pkg::pxm_group_t PIXEL_GROUP,
  input wire pxm_pkg::pxm_mpu_t   MPU_PINS,
  input wire logic [7:0]          MPU_DATA_OUT,
  input wire logic                MPU_DATA_OE,
  input wire pxm_pkg::pxm_rgb_t   VIDEO_RGB,
  input wire logic                VIDEO_VALID
);
  // ------
  // helpers
  // ------
  // load edges seen here late on purpose; strobes just after reset are not watched
  logic       ld_tog = 1'b0;
  logic       tog_s1;
  logic       tog_s2;
  logic [3:0] up;
  always_ff @(posedge LOAD_CLK) ld_tog <= ~ld_tog;
  always_ff @(posedge CORE_CLK) begin
    tog_s1 <= ld_tog;
    tog_s2 <= tog_s1;
    up     <= RST ? 4'h0 : (up == 4'h8 ? up : up + 4'h1);
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  sequence ce_fall; MPU_PINS.ce_n ##1 !MPU_PINS.ce_n; endsequence
  sequence ce_rise; !MPU_PINS.ce_n ##1 MPU_PINS.ce_n; endsequence
  // ------
  // checks
  // ------
  reset_quiet_a: assert property ($fell(RST) |-> !VIDEO_VALID && !MPU_DATA_OE)
    else $error("outputs busy after reset");
  idle_black_a: assert property (!VIDEO_VALID |-> VIDEO_RGB == BLANK_LEVEL)
    else $error("rgb not zero while idle");
  burst_min_a: assert property ($rose(VIDEO_VALID) |-> VIDEO_VALID [*4])
    else $error("pixel burst shorter than four");
  load_video_a: assert property (up == 4'h8 && $changed(tog_s2) |-> ##[1:6] VIDEO_VALID)
    else $error("captured group never reached video");
  read_answer_a: assert property (ce_fall ##0 MPU_PINS.rd_wr_n |-> ##[2:6] MPU_DATA_OE)
    else $error("read not answered");
  oe_cause_a: assert property ($rose(MPU_DATA_OE) |-> !$past(MPU_PINS.ce_n, 3))
    else $error("bus driven without access");
  oe_release_a: assert property (ce_rise |-> ##[2:6] !MPU_DATA_OE)
    else $error("bus not released");
  write_quiet_a: assert property (!MPU_PINS.rd_wr_n [*6] |-> !MPU_DATA_OE)
    else $error("bus driven during write");
  out_steady_a: assert property (MPU_DATA_OE && $past(MPU_DATA_OE) |-> $stable(MPU_DATA_OUT))
    else $error("read data moved while driven");
endmodule : pxm_palette_mux_monitor

bind pxm_palette_mux pxm_palette_mux_monitor mon (.CORE_CLK(CORE_CLK), .RST(RST),
  .LOAD_CLK(LOAD_CLK), .PIXEL_GROUP(PIXEL_GROUP), .MPU_PINS(MPU_PINS),
  .MPU_DATA_OUT(MPU_DATA_OUT), .MPU_DATA_OE(MPU_DATA_OE), .VIDEO_RGB(VIDEO_RGB),
  .VIDEO_VALID(VIDEO_VALID));

// ---- pxm_fb_model.sv ----
// frame buffer model driving pixel groups and the load strobe
`timescale 1ns/1ps
module pxm_fb_model
  import pxm_pkg::*;
(
  input  wire logic                rst,
  output logic                     load_clk,
  output pxm_pkg::pxm_group_t      pix
);
  // ------
  // strobe
  // ------
  // free running only around reset so the load domain leaves reset, then still
  initial begin
    load_clk = 1'b0;
    pix = '0;
    #1;
    while (rst) #24 load_clk = ~load_clk;
    repeat (12) #24 load_clk = ~load_clk;
    load_clk = 1'b0;
  end
  task automatic send(input pxm_group_t g);
    pix = g;
    #24 load_clk = 1'b1;
    #24 load_clk = 1'b0;
    pix = ~g;
  endtask : send
endmodule : pxm_fb_model

// ---- tb_top.sv ----
// self-checking bench for the pixel multiplexer and palette lookup
`timescale 1ns/1ps
module tb_top;
  import pxm_pkg::*;
  logic       clk;
  logic       rst;
  logic       load_clk;
  pxm_group_t pix;
  pxm_mpu_t   mpu;
  logic [7:0] dout;
  logic       doe;
  pxm_rgb_t   rgb;
  logic       valid;
  pxm_rgb_t   col [PAL_DEPTH];
  pxm_rgb_t   ovl [OVL_DEPTH];
  logic [7:0] ctl = CTRL_RESET;
  int         mismatches;
  int         comparisons;

  pxm_fb_model fb (.rst(rst), .load_clk(load_clk), .pix(pix));
  pxm_palette_mux uut (.CORE_CLK(clk), .RST(rst), .LOAD_CLK(load_clk), .PIXEL_GROUP(pix),
    .MPU_PINS(mpu), .MPU_DATA_OUT(dout), .MPU_DATA_OE(doe), .VIDEO_RGB(rgb),
    .VIDEO_VALID(valid));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic stop_test();
    if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // ------
  // bus and video helpers
  // ------
  task automatic access(input logic [1:0] s, input logic rw, input logic [7:0] d,
                        output logic [7:0] q);
    mpu = '{1'b1, s, rw, d};
    repeat (4) @(negedge clk);
    mpu.ce_n = 1'b0;
    repeat (9) @(negedge clk);
    q = dout;
    if (rw) chk("read drive", 24'h1, {23'h0, doe});
    mpu.ce_n = 1'b1;
    repeat (5) @(negedge clk);
    chk("bus release", 24'h0, {23'h0, doe});
  endtask : access

  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    logic [7:0] q;
    access(s, 1'b0, d, q);
  endtask : wr

  task automatic put(input logic [1:0] s, input logic [7:0] a, input pxm_rgb_t v);
    wr(SEL_ADDR, a);
    for (int i = 2; i >= 0; i--) wr(s, v[8*i +: 8]);
    if (s == SEL_COLOR) col[a] = v;
    else ovl[a[1:0]] = v;
  endtask : put

  function automatic pxm_rgb_t want(input pxm_group_t g, input int l);
    logic [1:0] s;
    s = {g.overlay_select_high_lanes[l], g.overlay_select_low_lanes[l]};
    if (!g.blank_n) return BLANK_LEVEL;
    if (ctl[CTRL_OVL_EN_BIT] && s == OSEL_COLOR) return col[g.addr[l]];
    return ovl[s];
  endfunction : want

  // second group is sent nl core clock cycles after the first
  task automatic play(input pxm_group_t a, input pxm_group_t b, input int ng, input int nl);
    int i;
    fork
      begin
        fb.send(a);
        repeat (nl) @(negedge clk);
        if (ng > 1) fb.send(b);
      end
    join_none
    i = 0;
    while (valid !== 1'b1 && i < 20) begin
      @(negedge clk);
      i++;
    end
    for (i = 0; i < ng * nl; i++) begin
      chk("pixel", want(i < nl ? a : b, i % nl), rgb);
      chk("valid", 24'h1, {23'h0, valid});
      @(negedge clk);
    end
    chk("idle", 24'h0, {23'h0, valid});
  endtask : play

  // ------
  // scenarios
  // ------
  task automatic t_palette();
    logic [7:0] q;
    for (int a = 1; a <= 4; a++) put(SEL_COLOR, 8'(a), {8'(a), 8'(a + 16), 8'(240 - a)});
    for (int k = 0; k < 4; k++) put(SEL_OVERLAY, 8'(k), {8'(k + 128), 8'h40, 8'(k + 15)});
    wr(SEL_ADDR, 8'h03);
    for (int i = 2; i >= 0; i--) begin
      access(SEL_COLOR, 1'b1, 8'h00, q);
      chk("palette read", {16'h0, col[3][8*i +: 8]}, {16'h0, q});
    end
    wr(SEL_ADDR, 8'h02);
    for (int i = 2; i >= 0; i--) begin
      access(SEL_OVERLAY, 1'b1, 8'h00, q);
      chk("overlay read", {16'h0, ovl[2][8*i +: 8]}, {16'h0, q});
    end
    access(SEL_ADDR, 1'b1, 8'h00, q);
    chk("address read", 24'h03, {16'h0, q});
  endtask : t_palette

  task automatic t_four();
    pxm_group_t ga;
    pxm_group_t gb;
    ga = {1'b1, 5'h06, 5'h0a, 40'h55_04_03_02_01};
    gb = {1'b1, 5'h00, 5'h00, 40'h55_01_02_03_04};
    play(ga, gb, 2, 4);
  endtask : t_four

  task automatic t_five();
    logic [7:0] q;
    wr(SEL_CTRL, 8'h80);
    ctl = 8'h80;
    access(SEL_CTRL, 1'b1, 8'h00, q);
    chk("control read", 24'h80, {16'h0, q});
    play({1'b1, 5'h0c, 5'h0a, 40'h01_02_03_04_01}, '0, 1, 5);
  endtask : t_five

  task automatic t_blank();
    pxm_group_t ga;
    wr(SEL_CTRL, 8'hc0);
    ctl = 8'hc0;
    ga = {1'b0, 5'h00, 5'h00, 40'h04_03_02_01_04};
    play(ga, {1'b1, 5'h00, 5'h10, 40'h55_04_03_02_01}, 2, 5);
  endtask : t_blank

  initial begin
    rst = 1'b1;
    mpu = '{1'b1, SEL_ADDR, 1'b0, 8'h00};
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (20) @(negedge clk);
    t_palette();
    t_four();
    t_five();
    t_blank();
    stop_test();
  end

  initial begin
    #1_000_000;
    mismatches++;
    stop_test();
  end
endmodule : tb_top
